// ### sync_serial_frame_engine_cfg.svh
// Constants of the synchronous serial port frame engine
`ifndef SYNC_SERIAL_FRAME_ENGINE_CFG_SVH
`define SYNC_SERIAL_FRAME_ENGINE_CFG_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define SSFE_WORD_W 16
`define SSFE_DIV_W 8
`define SSFE_IDX_W 4

// ----------------------------------------
// Word lengths, as top bit index
// ----------------------------------------
`define SSFE_MIN_TOP 4'h3
`define SSFE_CMD_TOP 4'h7

// ----------------------------------------
// Pin levels at reset
// ----------------------------------------
`define SSFE_SCLK_RST 1'b0
`define SSFE_FRAME_RST 1'b1
`define SSFE_TX_RST 1'b0

`endif

// ### sync_serial_frame_engine_pkg.sv
// Types of the synchronous serial port frame engine
`include "sync_serial_frame_engine_cfg.svh"

package sync_serial_frame_engine_pkg;

    // ----------------------------------------
    // Modes and states
    // ----------------------------------------
    typedef enum logic [1:0] {FMT_SPI, FMT_PULSE, FMT_CMDRSP} format_t;

    typedef enum logic [2:0] {ST_IDLE, ST_START, ST_CMD, ST_WAIT, ST_BITS, ST_TAIL} state_t;

    // ----------------------------------------
    // Carriers
    // ----------------------------------------
    typedef struct packed {
        logic enable;
        format_t format;
        logic clkPhase;
        logic clkInvert;
        logic [`SSFE_IDX_W-1:0] dataSize;
        logic [`SSFE_DIV_W-1:0] divider;
    } port_cfg_t;

    typedef struct packed {
        logic serialClock;
        logic frameSelectLine;
        logic portTransmitLine;
    } serial_pins_t;

endpackage : sync_serial_frame_engine_pkg

// ### sync_serial_frame_engine.sv
// Serial frame engine of the synchronous serial port master
`timescale 1ns/100ps

`include "sync_serial_frame_engine_cfg.svh"

// What this block does
// RL1: Words are 4 to 16 bits as programmed, sent most significant bit first.
// RL2: Serial clock idles low and toggles only while a word is transferred.
// RL3: SPI and command-response frame line is active low for the whole frame.
// RL4: Pulse format raises frame line one clock period from a rising edge.
// RL5: Command-response: data changes on falling edge, captured on rising edge.
// RL6: Pulse format: data changes on rising edge, captured on falling edge.
// RL7: SPI offers selectable clock edge and phase, four configurations.
// RL8: Command-response sends 8-bit command, ignores receive, then reads 4-16 bits.
// RL9: Slave decodes command in one wait clock, then drives reply on falling edges.
// RL10: Pulse format pulses frame and loads word, first bit on next rising edge.
// RL11: Pulse format stores received word half a period after last bit capture, on a rising edge only when a next word follows.
// RL12: Transmit line keeps last bit when idle, goes zero on disable or reset.
// RL13: SPI and command-response idle: clock low, frame high, transmit keeps last bit.
// RL14: SPI frame fall loads word, first bit half a period later, with a clock edge only when clkPhase differs from clkInvert.
// RL15: SPI slave drives first reply bit as soon as frame goes low.
// RL16: Single transfer: frame rises one period after last capture, storing word.
// RL17: Slave may release receive line after last capture or at frame rise.
// RL18: Continuous SPI and command-response transfers keep frame low, words back to back, stored at once.
// RL19: Continuous command-response: next command follows the last reply bit.
// RL20: Command-response frame starts on a command write, first bit at frame fall.
// RL21: Pulse format holds clock and frame low while idle.
// RL22: With no next word at frame end, return to the format's idle levels.
module sync_serial_frame_engine
    import sync_serial_frame_engine_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Configuration
    input wire port_cfg_t portCfg,
    // Transmit words
    input wire logic txValid,
    input wire logic [`SSFE_WORD_W-1:0] txData,
    output logic txReady,
    // Received words
    output logic rxValid,
    output logic [`SSFE_WORD_W-1:0] rxData,
    // Status
    output logic busy,
    // Serial pins
    output serial_pins_t pinsOut,
    input wire logic portReceiveLine
);

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    state_t state_reg;
    state_t stateNext;
    logic half_reg;
    logic halfNext;
    logic [`SSFE_IDX_W-1:0] bitIdx_reg;
    logic [`SSFE_IDX_W-1:0] bitNext;
    logic [`SSFE_IDX_W-1:0] sizeTop;
    logic [`SSFE_DIV_W-1:0] divCount_reg;
    logic [`SSFE_WORD_W-1:0] txWord_reg;
    logic [`SSFE_WORD_W-1:0] driveSrc;
    logic [`SSFE_WORD_W-1:0] rxShift_reg;
    logic rxMeta_reg;
    logic rxSync_reg;
    logic halfTick;
    logic lastBit;
    logic loadWord;
    logic driveBit;
    logic sampleBit;
    logic storeRx;
    logic highHalf;
    logic sclkNext;
    logic frameNext;
    format_t fmt;
    logic sclk_reg;
    logic frame_reg;
    logic txLine_reg;

    // One flop per pin, gathered here so each pin has a single driver
    assign pinsOut = '{serialClock: sclk_reg, frameSelectLine: frame_reg, portTransmitLine: txLine_reg};
    assign fmt = portCfg.format;
    assign halfTick = (divCount_reg == portCfg.divider);
    assign lastBit = (bitIdx_reg == '0);
    assign txReady = loadWord;
    assign busy = (state_reg != ST_IDLE);
    assign driveSrc = loadWord ? txData : txWord_reg;

    // Reserved sizes below four bits are raised to four
    assign sizeTop = (portCfg.dataSize < `SSFE_MIN_TOP) ? `SSFE_MIN_TOP : portCfg.dataSize; // RL1

    // ----------------------------------------
    // Receive line synchroniser
    // ----------------------------------------
    // Two cycles of latency; a half period of three cycles or more keeps sampling correct
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rxMeta_reg <= 1'b0;
            rxSync_reg <= 1'b0;
        end
        else
        begin
            rxMeta_reg <= portReceiveLine;
            rxSync_reg <= rxMeta_reg;
        end
    end

    // ----------------------------------------
    // Half period divider
    // ----------------------------------------
    // Stopped while idle so every frame starts on a fresh half period
    always_ff @(posedge sys_clk)
    begin
        if (rst || state_reg == ST_IDLE || halfTick)
            divCount_reg <= '0;
        else
            divCount_reg <= divCount_reg + 1'b1;
    end

    // ----------------------------------------
    // Sequencer decisions
    // ----------------------------------------
    always_comb
    begin
        stateNext = state_reg;
        halfNext = half_reg;
        bitNext = bitIdx_reg;
        loadWord = 1'b0;
        driveBit = 1'b0;
        sampleBit = 1'b0;
        storeRx = 1'b0;
        if (!portCfg.enable)
        begin
            stateNext = ST_IDLE;
            halfNext = 1'b0;
        end
        else
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (txValid)
                    begin
                        loadWord = 1'b1;
                        halfNext = 1'b0;
                        if (fmt == FMT_CMDRSP)
                        begin
                            stateNext = ST_CMD; // RL20
                            bitNext = `SSFE_CMD_TOP;
                            driveBit = 1'b1;
                        end
                        else
                        begin
                            stateNext = ST_START; // RL10 RL14
                            bitNext = sizeTop;
                        end
                    end
                end
                ST_START:
                begin
                    if (halfTick)
                    begin
                        if (fmt == FMT_PULSE && !half_reg)
                            halfNext = 1'b1; // RL4
                        else
                        begin
                            stateNext = ST_BITS;
                            halfNext = 1'b0;
                            driveBit = 1'b1; // RL10 RL14
                        end
                    end
                end
                ST_CMD:
                begin
                    if (halfTick)
                    begin
                        if (!half_reg)
                            halfNext = 1'b1;
                        else if (lastBit)
                        begin
                            stateNext = ST_WAIT; // RL8
                            halfNext = 1'b0;
                        end
                        else
                        begin
                            halfNext = 1'b0;
                            bitNext = bitIdx_reg - 1'b1;
                            driveBit = 1'b1; // RL5
                        end
                    end
                end
                ST_WAIT:
                begin
                    // One idle clock for the slave to decode the command
                    if (halfTick)
                    begin
                        if (!half_reg)
                            halfNext = 1'b1;
                        else
                        begin
                            stateNext = ST_BITS; // RL9
                            halfNext = 1'b0;
                            bitNext = sizeTop;
                        end
                    end
                end
                ST_BITS:
                begin
                    if (halfTick)
                    begin
                        if (!half_reg)
                        begin
                            halfNext = 1'b1;
                            sampleBit = 1'b1; // RL5 RL6
                        end
                        else if (!lastBit)
                        begin
                            halfNext = 1'b0;
                            bitNext = bitIdx_reg - 1'b1;
                            // Reply phase is half duplex: the line keeps the last command bit
                            driveBit = (fmt != FMT_CMDRSP); // RL8
                        end
                        else if (txValid)
                        begin
                            storeRx = 1'b1; // RL18 RL11
                            loadWord = 1'b1;
                            halfNext = 1'b0;
                            if (fmt == FMT_PULSE)
                            begin
                                stateNext = ST_START; // RL4
                                bitNext = sizeTop;
                            end
                            else if (fmt == FMT_CMDRSP)
                            begin
                                stateNext = ST_CMD; // RL19
                                bitNext = `SSFE_CMD_TOP;
                                driveBit = 1'b1;
                            end
                            else
                            begin
                                bitNext = sizeTop; // RL18
                                driveBit = 1'b1;
                            end
                        end
                        else if (fmt == FMT_PULSE)
                        begin
                            storeRx = 1'b1; // RL11
                            stateNext = ST_IDLE; // RL22
                        end
                        else
                        begin
                            stateNext = ST_TAIL;
                            halfNext = 1'b0;
                        end
                    end
                end
                ST_TAIL:
                begin
                    if (halfTick)
                    begin
                        storeRx = 1'b1; // RL16
                        stateNext = ST_IDLE; // RL22
                    end
                end
                default:
                    stateNext = ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // Sequencer state
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            half_reg <= 1'b0;
            bitIdx_reg <= '0;
        end
        else
        begin
            state_reg <= stateNext;
            half_reg <= halfNext;
            bitIdx_reg <= bitNext;
        end
    end

    // ----------------------------------------
    // Transmit path
    // ----------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (rst)
            txWord_reg <= '0;
        else if (loadWord)
            txWord_reg <= txData;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst || !portCfg.enable)
            txLine_reg <= `SSFE_TX_RST; // RL12 RL13
        else if (driveBit)
            txLine_reg <= driveSrc[bitNext]; // RL1
    end

    // ----------------------------------------
    // Receive path
    // ----------------------------------------
    // Shifting into a cleared register leaves the word right justified, upper bits zero
    always_ff @(posedge sys_clk)
    begin
        if (rst || loadWord)
            rxShift_reg <= '0;
        else if (sampleBit)
            rxShift_reg <= {rxShift_reg[`SSFE_WORD_W-2:0], rxSync_reg};
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            rxValid <= 1'b0;
            rxData <= '0;
        end
        else
        begin
            rxValid <= storeRx;
            if (storeRx)
                rxData <= rxShift_reg;
        end
    end

    // ----------------------------------------
    // Clock and frame pins
    // ----------------------------------------
    always_comb
    begin
        case (fmt)
            FMT_PULSE: highHalf = 1'b0; // RL6
            FMT_CMDRSP: highHalf = 1'b1; // RL5
            default: highHalf = !portCfg.clkPhase; // RL7
        endcase
        case (stateNext)
            ST_BITS: sclkNext = (halfNext == highHalf) ^ (fmt == FMT_SPI && portCfg.clkInvert); // RL7
            ST_CMD: sclkNext = halfNext;
            ST_WAIT: sclkNext = halfNext;
            ST_START: sclkNext = (fmt == FMT_PULSE) && !halfNext; // RL4
            default: sclkNext = 1'b0; // RL2
        endcase
        if (fmt == FMT_PULSE)
            frameNext = (stateNext == ST_START); // RL4 RL21
        else
            frameNext = (stateNext == ST_IDLE); // RL3 RL13
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sclk_reg <= `SSFE_SCLK_RST;
            frame_reg <= `SSFE_FRAME_RST;
        end
        else
        begin
            sclk_reg <= sclkNext; // RL2
            frame_reg <= frameNext; // RL3
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    property p_idleClockLow;
        state_reg == ST_IDLE |-> !pinsOut.serialClock;
    endproperty
    a_idleClockLow: assert property (p_idleClockLow) else $error("serial clock high while idle"); // RL2

    property p_selectLow;
        fmt != FMT_PULSE && state_reg != ST_IDLE |-> !pinsOut.frameSelectLine;
    endproperty
    a_selectLow: assert property (p_selectLow) else $error("select not low during frame"); // RL3

    property p_pulseAtRise;
        fmt == FMT_PULSE && $rose(pinsOut.frameSelectLine) |-> pinsOut.serialClock;
    endproperty
    a_pulseAtRise: assert property (p_pulseAtRise) else $error("frame pulse not on rising clock"); // RL4

    property p_pulseLowElse;
        fmt == FMT_PULSE && $past(fmt) == FMT_PULSE && state_reg != ST_START |-> !pinsOut.frameSelectLine;
    endproperty
    a_pulseLowElse: assert property (p_pulseLowElse) else $error("pulse frame high outside start"); // RL21

    property p_noCmdSample;
        fmt == FMT_CMDRSP && (state_reg == ST_CMD || state_reg == ST_WAIT) |-> rxShift_reg == '0;
    endproperty
    a_noCmdSample: assert property (p_noCmdSample) else $error("receive sampled during command"); // RL8

    property p_txZeroOff;
        !portCfg.enable |=> !pinsOut.portTransmitLine;
    endproperty
    a_txZeroOff: assert property (p_txZeroOff) else $error("transmit line not zero when disabled"); // RL12

    property p_offLevels;
        !portCfg.enable && fmt != FMT_PULSE |=> pinsOut.frameSelectLine && !pinsOut.serialClock;
    endproperty
    a_offLevels: assert property (p_offLevels) else $error("wrong idle levels when disabled"); // RL13

    property p_storeAtDeassert;
        portCfg.enable && fmt == FMT_SPI && $rose(pinsOut.frameSelectLine) |-> rxValid;
    endproperty
    a_storeAtDeassert: assert property (p_storeAtDeassert) else $error("word not stored at frame end"); // RL16

    property p_sizeLoaded;
        fmt == FMT_SPI && loadWord |=> bitIdx_reg == $past(sizeTop);
    endproperty
    a_sizeLoaded: assert property (p_sizeLoaded) else $error("word length not loaded"); // RL1

endmodule : sync_serial_frame_engine

// ### sync_serial_slave_model.sv
// Behavioural off-chip slave on the far side of the serial frame engine
`timescale 1ns/100ps

module sync_serial_slave_model
    import sync_serial_frame_engine_pkg::*;
(
    // Clock used to watch the pins
    input wire logic sys_clk,
    // Configuration shared with the master
    input wire port_cfg_t portCfg,
    // Serial pins
    input wire serial_pins_t pinsOut,
    output logic portReceiveLine
);
    logic [15:0] replyQ[$];
    logic [15:0] gotQ[$];
    logic [15:0] shIn = 16'h0000;
    logic [15:0] shOut = 16'h0000;
    logic clkD = 1'b0, frameD = 1'b1, rxOut = 1'b0, pend = 1'b0;
    logic rise, fall, frame;
    int idx = 0, cnt = 0, pst = 0, n = 4;

    initial portReceiveLine = 1'b0;

    function automatic logic [15:0] peek();
        return (replyQ.size() != 0) ? replyQ[0] : 16'h0000;
    endfunction : peek

    task automatic sample();
        if (idx == 0 && replyQ.size() != 0)
            replyQ.delete(0);
        shIn = {shIn[14:0], pinsOut.portTransmitLine};
        pend = 1'b1;
        idx++;
        if (idx == n)
        begin
            gotQ.push_back(shIn);
            shIn = 16'h0000;
            idx = 0;
            shOut = peek();
        end
    endtask : sample

    // ----------------------------------------
    // Pin watcher, one system clock behind the pins
    // ----------------------------------------
    always @(posedge sys_clk)
    begin
        rise = pinsOut.serialClock && !clkD;
        fall = !pinsOut.serialClock && clkD;
        frame = pinsOut.frameSelectLine;
        if (frameD && !frame)
        begin
            n = int'(portCfg.dataSize) + 1;
            idx = 0;
            cnt = 0;
            pend = 1'b0;
            shIn = 16'h0000;
            shOut = peek();
            if (portCfg.format == FMT_SPI)
                rxOut = shOut[n-1];
        end
        // A released line flips, so a stale bit never passes for data
        if (!frameD && frame && portCfg.format != FMT_PULSE)
            rxOut = ~rxOut;
        if (portCfg.format == FMT_SPI && !frame)
        begin
            if ((rise || fall) && (rise == (portCfg.clkPhase == portCfg.clkInvert)))
                sample();
            else if ((rise || fall) && pend)
            begin
                pend = 1'b0;
                rxOut = shOut[n-1-idx];
            end
        end
        else if (portCfg.format == FMT_PULSE)
        begin
            if (rise && frame)
            begin
                pst = 1;
                n = int'(portCfg.dataSize) + 1;
                idx = 0;
                shIn = 16'h0000;
                shOut = peek();
            end
            else if (rise && pst == 2)
                rxOut = shOut[n-1-idx];
            else if (fall && pst == 1)
                pst = 2;
            else if (fall && pst == 2)
            begin
                sample();
                if (idx == 0)
                    pst = 0;
                if (idx == 0)
                    rxOut = ~rxOut;
            end
        end
        else if (portCfg.format == FMT_CMDRSP && !frame)
        begin
            if (rise)
                cnt++;
            if (rise && cnt <= 8)
                shIn = {shIn[14:0], pinsOut.portTransmitLine};
            if (rise && cnt == 8)
                gotQ.push_back(shIn);
            if (rise && cnt == 9)
                sample_reply();
            if (rise && cnt == 9 + n)
                cnt = 0;
            if (rise && cnt == 0)
                shIn = 16'h0000;
            if (fall)
                rxOut = (cnt >= 9) ? shOut[n+8-cnt] : ~rxOut;
        end
        clkD = pinsOut.serialClock;
        frameD = frame;
        portReceiveLine <= rxOut;
    end

    // The command is decoded during the wait clock, then the reply is fixed
    task automatic sample_reply();
        shOut = peek();
        if (replyQ.size() != 0)
            replyQ.delete(0);
    endtask : sample_reply
endmodule : sync_serial_slave_model

// ### sync_serial_frame_engine_tb.sv
// Self-checking bench of the serial frame engine against a queue model
`timescale 1ns/100ps

`include "sync_serial_frame_engine_cfg.svh"

module sync_serial_frame_engine_tb
    import sync_serial_frame_engine_pkg::*;
;
    // Divider 7 gives a half period of 8 cycles, a 160 ns serial clock
    localparam int H = 8;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    port_cfg_t portCfg;
    logic txValid, txReady, rxValid, busy, portReceiveLine, lastBit;
    logic [`SSFE_WORD_W-1:0] txData, rxData;
    serial_pins_t pinsOut;
    logic [15:0] rxExp[$], txExp[$];
    int fails = 0, cmp_count = 0, cyc = 0, hc = 0, n;

    always #5 sys_clk = ~sys_clk;

    sync_serial_frame_engine u_dut (.sys_clk(sys_clk), .rst(rst), .portCfg(portCfg), .txValid(txValid),
        .txData(txData), .txReady(txReady), .rxValid(rxValid), .rxData(rxData), .busy(busy),
        .pinsOut(pinsOut), .portReceiveLine(portReceiveLine));

    sync_serial_slave_model u_slave (.sys_clk(sys_clk), .portCfg(portCfg), .pinsOut(pinsOut),
        .portReceiveLine(portReceiveLine));

    task automatic wrap_up();
        if (fails == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            fails++;
            $display("BAD %0t %s", $time, msg);
        end
    endtask : chk

    // ----------------------------------------
    // Monitors
    // ----------------------------------------
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            chk(1'b0, "timeout");
            wrap_up();
        end
    end

    always @(negedge sys_clk)
        if (!rst && rxValid === 1'b1)
        begin
            if (rxExp.size() == 0)
                chk(1'b0, "unexpected received word");
            else
                chk(rxData === rxExp.pop_front(), "received word");
            if (portCfg.format == FMT_PULSE)
                chk(pinsOut.serialClock === (rxExp.size() != 0), "store not at rising clock");
            else
                chk(pinsOut.frameSelectLine === (rxExp.size() == 0), "frame level at store");
        end

    always @(negedge sys_clk)
        if (busy === 1'b1 && portCfg.format == FMT_PULSE && pinsOut.frameSelectLine === 1'b1)
        begin
            if (hc == 0)
                chk(pinsOut.serialClock === 1'b1, "pulse not at rising clock");
            hc++;
        end
        else if (hc != 0)
        begin
            chk(hc == 2 * H, "frame pulse width");
            hc = 0;
        end

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    task automatic send(input logic [15:0] w);
        logic hit;
        txValid <= 1'b1;
        txData <= w;
        do
        begin
            @(negedge sys_clk);
            hit = txReady;
            @(posedge sys_clk);
        end while (hit !== 1'b1);
    endtask : send

    task automatic run_frame(input int words);
        logic [15:0] w, r;
        int bits;
        n = int'(portCfg.dataSize) + 1;
        bits = (portCfg.format == FMT_CMDRSP) ? 8 : n;
        for (int k = 0; k < words; k++)
        begin
            w = 16'($urandom);
            r = 16'($urandom);
            u_slave.replyQ.push_back(r);
            rxExp.push_back(r & 16'((1 << n) - 1));
            txExp.push_back(w & 16'((1 << bits) - 1));
            lastBit = w[0];
            send(w);
        end
        txValid <= 1'b0;
        do
            @(negedge sys_clk);
        while (busy !== 1'b0);
        repeat (2 * H) @(negedge sys_clk);
        chk(pinsOut.serialClock === 1'b0, "clock not idle");
        chk(pinsOut.frameSelectLine === (portCfg.format != FMT_PULSE), "frame not idle");
        chk(pinsOut.portTransmitLine === lastBit, "transmit line lost last bit");
        chk(rxExp.size() == 0, "received words missing");
        chk(u_slave.gotQ.size() == txExp.size(), "sent word count");
        while (u_slave.gotQ.size() != 0 && txExp.size() != 0)
            chk(u_slave.gotQ.pop_front() === txExp.pop_front(), "sent word");
        txExp.delete();
        u_slave.gotQ.delete();
    endtask : run_frame

    initial
    begin
        port_cfg_t c;
        c = '0;
        c.divider = 8'h07;
        c.dataSize = 4'h7;
        portCfg = c;
        txValid = 1'b0;
        txData = 16'h0000;
        lastBit = 1'b0;
        void'($urandom(32'h71dd3c46));
        repeat (3) @(negedge sys_clk);
        chk(pinsOut === serial_pins_t'{1'b0, 1'b1, 1'b0}, "reset levels");
        @(posedge sys_clk);
        rst <= 1'b0;
        // Four clock modes, then pulse and command formats, at both size limits
        for (int t = 0; t < 6; t++)
            for (int s = 0; s < 3; s++)
            begin
                @(posedge sys_clk);
                c.enable = 1'b1;
                c.format = (t < 4) ? FMT_SPI : ((t == 4) ? FMT_PULSE : FMT_CMDRSP);
                c.clkPhase = t[0];
                c.clkInvert = t[1];
                c.dataSize = (s == 0) ? 4'h3 : ((s == 1) ? 4'hf : 4'($urandom_range(15, 3)));
                portCfg <= c;
                @(posedge sys_clk);
                run_frame(s + 1);
            end
        // Disable in mid-frame: the partial word must be dropped
        c.format = FMT_SPI;
        c.dataSize = 4'hf;
        portCfg <= c;
        @(posedge sys_clk);
        send(16'hffff);
        txValid <= 1'b0;
        repeat (10 * H) @(posedge sys_clk);
        c.enable = 1'b0;
        portCfg <= c;
        repeat (3) @(negedge sys_clk);
        chk(pinsOut === serial_pins_t'{1'b0, 1'b1, 1'b0} && busy === 1'b0, "disabled levels");
        repeat (4 * H) @(negedge sys_clk);
        wrap_up();
    end
endmodule : sync_serial_frame_engine_tb
